/* design/smsl_top.sv */
// Multiframe sync, S/Q channel, loops and test pulses with AHB-Lite slave
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module smsl_top #(
  parameter int FRAME_CYC = smsl_pkg::FRAME_CYC_D,
  parameter int SP_CYC    = smsl_pkg::SP_CYC_D
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rx_frame_stb,
  input  wire logic        rx_fa_bit,
  input  wire logic        rx_m_bit,
  input  wire logic        rx_s_bit,
  input  wire logic        rx_b_bit,
  input  wire logic        rx_d_bit,
  input  wire logic        line_signal,
  input  wire logic        awake_det,
  input  wire logic        info3_sync,
  input  wire logic        hdlc_tx_bit,
  input  wire logic        pcm_in_bit,
  output logic             tx_fa_bit,
  output logic             s_change_pulse,
  output logic             hdlc_rx_bit,
  output logic             pcm_out_bit,
  output logic             line_tx_b_bit,
  output logic             line_tx_d_bit,
  output logic             line_pos,
  output logic             line_neg,
  output logic             line_drive_en,
  output logic             rx_from_tx,
  output logic             frame_stb_out,
  output logic             pwr_up
);
  import smsl_pkg::*;

  // Slot of a frame number: {in S/Q frame, index 0..3}
  function automatic logic [2:0] frame_slot(input logic [4:0] f);
    unique case (f)
      FR_S1:   frame_slot = 3'h4;
      FR_S2:   frame_slot = 3'h5;
      FR_S3:   frame_slot = 3'h6;
      FR_S4:   frame_slot = 3'h7;
      default: frame_slot = 3'h0;
    endcase
  endfunction : frame_slot

  logic [2:0]  mode_reg;
  logic [3:0]  cmd_reg;
  logic [3:0]  s_bit_receive_reg;
  logic [3:0]  sqx_reg;
  logic [3:0]  indication_reg;
  logic [2:0]  s_work_reg;
  logic [4:0]  fcnt_reg;
  logic [4:0]  fcnt_next;
  logic [4:0]  good_reg;
  logic [4:0]  good_next;
  logic        lock_reg;
  logic        lock_next;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [15:0] int_cnt_reg;
  logic        int_stb;
  logic        fstb;
  logic [4:0]  fcnt_adv;
  logic        exp_m;
  logic [2:0]  slot;
  logic [15:0] tcnt_reg;
  logic        pol_reg;
  logic        test_on;
  logic        cpulse_mode;
  logic [15:0] tper;
  logic        tick;
  logic        aloop;
  logic        addr_ok;
  logic [31:0] rd_val;

  // Bus slave: zero wait states, read data latched in the address phase
  assign addr_ok = hsel & hready & htrans[1];

  always_comb begin
    rd_val = 32'h0;
    unique case (haddr[7:0])
      MODE_OFS: rd_val = {29'h0, mode_reg};
      CMD_OFS:  rd_val = {28'h0, cmd_reg};
      SRX_OFS:  rd_val = {27'h0, lock_reg, s_bit_receive_reg};
      QTX_OFS:  rd_val = {28'h0, sqx_reg};
      IND_OFS:  rd_val = {27'h0, pwr_up, indication_reg};
      default:  rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h0;
      hrdata      <= 32'h0;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_val;
        end
      end
    end
  end

  // Software registers; unmapped writes are dropped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 3'h0;
      cmd_reg  <= CMD_RST;
      sqx_reg  <= 4'h0;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        MODE_OFS: begin
          mode_reg[MODE_MFDIS] <= hwdata[MODE_MFDIS];
          mode_reg[MODE_RLOOP] <= hwdata[MODE_RLOOP];
          mode_reg[MODE_DLOOP] <= hwdata[MODE_DLOOP] & ~hwdata[MODE_RLOOP];
        end
        CMD_OFS:  cmd_reg <= hwdata[3:0];
        QTX_OFS:  sqx_reg <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_cnt_reg <= 16'h0;
    end else if (int_stb) begin
      int_cnt_reg <= 16'h0;
    end else begin
      int_cnt_reg <= int_cnt_reg + 16'h1;
    end
  end
  assign int_stb = (int_cnt_reg == 16'(FRAME_CYC - 1));
  assign fstb = mode_reg[MODE_DLOOP] ? int_stb : rx_frame_stb;

  assign fcnt_adv = (fcnt_reg == MF_LEN) ? FR_S1 : fcnt_reg + 5'h1;
  // M is one only in frame 1
  assign exp_m = (fcnt_adv == FR_S1);

  always_comb begin
    fcnt_next = fcnt_reg;
    good_next = good_reg;
    lock_next = lock_reg;
    if (mode_reg[MODE_MFDIS]) begin
      good_next = 5'h0;
      lock_next = 1'b0;
    end else if (fstb && lock_reg) begin
      fcnt_next = fcnt_adv;
      if (rx_m_bit != exp_m) begin
        lock_next = 1'b0;
        good_next = 5'h0;
      end
    end else if (fstb) begin
      if (rx_m_bit) begin
        fcnt_next = FR_S1;
        good_next = 5'h1;
      end else if (good_reg != 5'h0 && !exp_m) begin
        fcnt_next = fcnt_adv;
        good_next = good_reg + 5'h1;
        lock_next = (good_reg == MF_LEN - 5'h1);
      end else begin
        good_next = 5'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fcnt_reg <= FR_S1;
      good_reg <= 5'h0;
      lock_reg <= 1'b0;
    end else begin
      fcnt_reg <= fcnt_next;
      good_reg <= good_next;
      lock_reg <= lock_next;
    end
  end

  assign slot = frame_slot(fcnt_next);

  // S capture; compare on frame 16
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_work_reg     <= 3'h0;
      s_bit_receive_reg <= 4'h0;
      s_change_pulse <= 1'b0;
    end else begin
      s_change_pulse <= 1'b0;
      if (fstb && lock_next && slot[2]) begin
        if (slot[1:0] != 2'h3) begin
          s_work_reg[slot[1:0]] <= rx_s_bit;
        end else begin
          s_bit_receive_reg <= {rx_s_bit, s_work_reg};
          s_change_pulse <= ({rx_s_bit, s_work_reg} != s_bit_receive_reg);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_fa_bit <= 1'b0;
    end else if (fstb) begin
      if (lock_next) begin
        tx_fa_bit <= slot[2] & sqx_reg[slot[1:0]];
      end else begin
        tx_fa_bit <= rx_fa_bit;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hdlc_rx_bit   <= 1'b0;
      pcm_out_bit   <= 1'b0;
      line_tx_b_bit <= 1'b0;
      line_tx_d_bit <= 1'b0;
      frame_stb_out <= 1'b0;
    end else begin
      frame_stb_out <= fstb;
      hdlc_rx_bit   <= mode_reg[MODE_DLOOP] ? hdlc_tx_bit : rx_d_bit;
      pcm_out_bit   <= mode_reg[MODE_DLOOP] ? pcm_in_bit : rx_b_bit;
      line_tx_b_bit <= mode_reg[MODE_RLOOP] ? rx_b_bit : hdlc_tx_bit;
      line_tx_d_bit <= hdlc_tx_bit;
    end
  end

  // Power up on line signal or wake
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_up <= 1'b0;
    end else if (line_signal || cmd_reg == CMD_WAKE) begin
      pwr_up <= 1'b1;
    end
  end

  assign aloop = (cmd_reg == CMD_ALOOP);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      line_drive_en <= 1'b0;
      rx_from_tx    <= 1'b0;
    end else begin
      line_drive_en <= pwr_up & ~aloop;
      rx_from_tx    <= aloop;
    end
  end

  // Awake test wins because a live line makes the loop result meaningless
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      indication_reg <= IND_RST;
    end else if (aloop) begin
      if (awake_det) begin
        indication_reg <= IND_AWAKE;
      end else if (info3_sync) begin
        indication_reg <= IND_LOOP;
      end
    end
  end

  assign cpulse_mode = (cmd_reg == CMD_CPULSE);
  assign test_on  = cpulse_mode | (cmd_reg == CMD_SPULSE);
  assign tper = cpulse_mode ? 16'(BIT_CYC) : 16'(SP_CYC);
  // Compare with >= so a switch to a shorter period cannot run past the end
  assign tick = (tcnt_reg >= tper - 16'h1);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tcnt_reg <= 16'h0;
      pol_reg  <= 1'b0;
    end else if (!test_on) begin
      tcnt_reg <= 16'h0;
    end else if (tick) begin
      tcnt_reg <= 16'h0;
      pol_reg  <= ~pol_reg;
    end else begin
      tcnt_reg <= tcnt_reg + 16'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      line_pos <= 1'b0;
      line_neg <= 1'b0;
    end else begin
      line_pos <= test_on & ~aloop & (tcnt_reg < 16'(BIT_CYC)) & pol_reg;
      line_neg <= test_on & ~aloop & (tcnt_reg < 16'(BIT_CYC)) & ~pol_reg;
    end
  end

  a_lock_after_count: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(lock_reg) |-> $past(good_reg) == MF_LEN - 5'h1)
    else $error("lock without twenty good frames");

  a_q_first_frame: assert property (@(posedge mclk) disable iff (!rst_b)
    fstb && lock_next && fcnt_next == FR_S1 |=> tx_fa_bit == $past(sqx_reg[0]))
    else $error("Q1 not sent in frame 1");

  a_fa_mirror: assert property (@(posedge mclk) disable iff (!rst_b)
    fstb && !lock_next |=> tx_fa_bit == $past(rx_fa_bit))
    else $error("framing bit not mirrored");

  a_s_change: assert property (@(posedge mclk) disable iff (!rst_b)
    s_change_pulse |-> s_bit_receive_reg != $past(s_bit_receive_reg)
      ##1 !s_change_pulse)
    else $error("S change pulse wrong");

  // Digital loop never with remote loop
  a_dlp_refused: assert property (@(posedge mclk) disable iff (!rst_b)
    mode_reg[MODE_RLOOP] |-> !mode_reg[MODE_DLOOP])
    else $error("digital loop with remote loop");

  a_aloop_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    aloop ##1 aloop |-> !line_drive_en && !line_pos && !line_neg)
    else $error("line driven in analog loop");

  a_mfd_unlock: assert property (@(posedge mclk) disable iff (!rst_b)
    mode_reg[MODE_MFDIS] |=> !lock_reg)
    else $error("lock held while disabled");

  a_hdlc_loop: assert property (@(posedge mclk) disable iff (!rst_b)
    mode_reg[MODE_DLOOP] |=> hdlc_rx_bit == $past(hdlc_tx_bit))
    else $error("digital loop broken");

  a_remote_loop: assert property (@(posedge mclk) disable iff (!rst_b)
    mode_reg[MODE_RLOOP] |=> line_tx_b_bit == $past(rx_b_bit)
      && line_tx_d_bit == $past(hdlc_tx_bit))
    else $error("remote loop path wrong");

  // Continuous pulses alternate each bit time
  a_scp_toggle: assert property (@(posedge mclk) disable iff (!rst_b)
    cpulse_mode && tick ##1 cpulse_mode |-> pol_reg != $past(pol_reg))
    else $error("continuous pulse polarity stuck");

endmodule : smsl_top

/* design/smsl_pkg.sv */
// Constants for the multiframe sync, S/Q and test-loop block
package smsl_pkg;
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS  = 8'h04;
  localparam logic [7:0] SRX_OFS  = 8'h08;
  localparam logic [7:0] QTX_OFS  = 8'h0c;
  localparam logic [7:0] IND_OFS  = 8'h10;
  localparam int MODE_MFDIS = 0;
  localparam int MODE_DLOOP = 1;
  localparam int MODE_RLOOP = 2;
  localparam int SRX_LOCK = 4;
  localparam int IND_PWR  = 4;
  localparam logic [4:0] MF_LEN  = 5'h14;
  localparam logic [4:0] FR_S1   = 5'h01;
  localparam logic [4:0] FR_S2   = 5'h06;
  localparam logic [4:0] FR_S3   = 5'h0b;
  localparam logic [4:0] FR_S4   = 5'h10;
  localparam logic [3:0] CMD_RST = 4'h1;
  localparam logic [3:0] CMD_SPULSE = 4'h2;
  localparam logic [3:0] CMD_CPULSE = 4'h3;
  localparam logic [3:0] CMD_ALOOP  = 4'ha;
  localparam logic [3:0] CMD_WAKE   = 4'hb;
  localparam logic [3:0] IND_LOOP   = 4'h0;
  localparam logic [3:0] IND_AWAKE  = 4'he;
  localparam logic [3:0] IND_RST = 4'h1;
  localparam int CLK_NS   = 40;
  localparam int FRAME_NS = 250000;
  localparam int SP_NS    = 250000;
  localparam int BIT_NS   = 5208;
  localparam int FRAME_CYC_D = FRAME_NS / CLK_NS;
  localparam int SP_CYC_D    = SP_NS / CLK_NS;
  localparam int BIT_CYC     = BIT_NS / CLK_NS;
endpackage : smsl_pkg

/* bench/smsl_nt_model.sv */
// Network-side frame source driving the received frame bits
`timescale 1ns/1ps
module smsl_nt_model #(
  parameter int FRAME_CYC = 64
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       m_err,
  input  wire logic [3:0] s_val,
  output logic            frame_stb,
  output logic            fa_bit,
  output logic            m_bit,
  output logic            s_bit,
  output logic [4:0]      frame_no
);
  int         cnt;
  logic [4:0] fn_next;
  assign fn_next = (frame_no == 5'h14) ? 5'h01 : frame_no + 5'h01;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      frame_stb <= 1'b0;
      frame_no <= 5'h14;
      fa_bit <= 1'b0;
      m_bit <= 1'b0;
      s_bit <= 1'b0;
    end else if (run && cnt == FRAME_CYC - 1) begin
      cnt <= 0;
      frame_stb <= 1'b1;
      frame_no <= fn_next;
      fa_bit <= fn_next inside {5'h01, 5'h06, 5'h0b, 5'h10};
      // M only in frame 1; m_err breaks it on purpose
      m_bit <= (fn_next == 5'h01) ^ m_err;
      // S bits only flow toward the terminal
      // S code repeats every multiframe while s_val is held
      case (fn_next)
        5'h01: s_bit <= s_val[0];
        5'h06: s_bit <= s_val[1];
        5'h0b: s_bit <= s_val[2];
        5'h10: s_bit <= s_val[3];
        default: s_bit <= 1'b0;
      endcase
    end else begin
      if (run) cnt <= cnt + 1;
      frame_stb <= 1'b0;
      // Stale bits are inverted so a late sample cannot pass by luck
      fa_bit <= ~fa_bit;
      m_bit <= ~m_bit;
      s_bit <= ~s_bit;
    end
  end
endmodule : smsl_nt_model

/* bench/smsl_tb_top.sv */
// Self-checking testbench for the multiframe sync and test-loop block
`timescale 1ns/1ps
module smsl_tb_top;
  import smsl_pkg::*;
  localparam int FC  = 64;
  localparam int SPC = 400;
  logic        mclk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        stb, fa, mb, sb, rx_b, rx_d, line_sig, awake, info3, htx;
  logic        pin, tx_fa, schg, hrx, pout, ltx_b, ltx_d, lpos, lneg;
  logic        ldrv, rft, fso, pwr, run, m_err;
  logic [3:0]  s_val;
  logic [4:0]  fno;
  int          bad_count, check_count, cyc, nchg;

  assign hready = hreadyout;
  smsl_top #(.FRAME_CYC(FC), .SP_CYC(SPC)) i_smsl_top (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rx_frame_stb(stb), .rx_fa_bit(fa), .rx_m_bit(mb),
    .rx_s_bit(sb), .rx_b_bit(rx_b), .rx_d_bit(rx_d),
    .line_signal(line_sig), .awake_det(awake), .info3_sync(info3),
    .hdlc_tx_bit(htx), .pcm_in_bit(pin), .tx_fa_bit(tx_fa),
    .s_change_pulse(schg), .hdlc_rx_bit(hrx), .pcm_out_bit(pout),
    .line_tx_b_bit(ltx_b), .line_tx_d_bit(ltx_d), .line_pos(lpos),
    .line_neg(lneg), .line_drive_en(ldrv), .rx_from_tx(rft),
    .frame_stb_out(fso), .pwr_up(pwr));
  smsl_nt_model #(.FRAME_CYC(FC)) i_smsl_nt_model (
    .mclk(mclk), .rst_b(rst_b), .run(run), .m_err(m_err),
    .s_val(s_val), .frame_stb(stb), .fa_bit(fa), .m_bit(mb),
    .s_bit(sb), .frame_no(fno));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Hang guard, generous against a run of about 6300 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (schg === 1'b1) nchg <= nchg + 1;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdc

  // Returns just after the edge that takes frame k
  task frame_at(input logic [4:0] k);
    do @(posedge mclk); while (!(stb === 1'b1 && fno == k));
    #1;
  endtask : frame_at

  task pulses(input int gap);
    int n, g;
    n = 0;
    g = 0;
    while (lpos === 1'b1) @(posedge mclk);
    while (lpos !== 1'b1) @(posedge mclk);
    while (lpos === 1'b1) begin
      @(posedge mclk);
      n++;
    end
    while (lneg !== 1'b1) begin
      @(posedge mclk);
      g++;
    end
    chk(n, BIT_CYC);
    chk(g, gap);
  endtask : pulses

  task t_reset;
    rdc(IND_OFS, {27'h0, 1'b0, IND_RST});
    rdc(SRX_OFS, 32'h0);
    rdc(8'h20, 32'h0);
    $display("Test reset done");
  endtask : t_reset

  task t_lock;
    wr(QTX_OFS, 32'h0000000a);
    s_val <= 4'h6;
    run <= 1'b1;
    frame_at(5'h13);
    rdc(SRX_OFS, 32'h0);
    frame_at(5'h14);
    rdc(SRX_OFS, 32'h10);
    frame_at(5'h01);
    chk(tx_fa, 1'b0);
    frame_at(5'h06);
    chk(tx_fa, 1'b1);
    frame_at(5'h0b);
    chk(tx_fa, 1'b0);
    frame_at(5'h10);
    chk(tx_fa, 1'b1);
    repeat (3) @(posedge mclk);
    rdc(SRX_OFS, 32'h16);
    chk(nchg, 1);
    $display("Test lock done");
  endtask : t_lock

  task t_loss;
    frame_at(5'h14);
    m_err <= 1'b1;
    frame_at(5'h01);
    chk(tx_fa, 1'b1);
    m_err <= 1'b0;
    rdc(SRX_OFS, 32'h06);
    wr(MODE_OFS, 32'h1);
    s_val <= 4'h9;
    frame_at(5'h14);
    frame_at(5'h14);
    rdc(SRX_OFS, 32'h06);
    chk(nchg, 1);
    wr(MODE_OFS, 32'h0);
    run <= 1'b0;
    $display("Test loss done");
  endtask : t_loss

  task t_loops;
    int n;
    wr(MODE_OFS, 32'h6);
    rdc(MODE_OFS, 32'h4);
    wr(MODE_OFS, 32'h2);
    htx <= 1'b1;
    pin <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({hrx, pout}, 2'b11);
    n = 0;
    while (fso !== 1'b1 && n < 2 * FC) begin
      @(posedge mclk);
      n++;
    end
    chk(fso, 1'b1);
    wr(MODE_OFS, 32'h4);
    htx <= 1'b0;
    rx_b <= 1'b1;
    rx_d <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({ltx_b, hrx, ltx_d}, 3'b110);
    wr(MODE_OFS, 32'h0);
    $display("Test loops done");
  endtask : t_loops

  task t_analog;
    wr(CMD_OFS, {28'h0, CMD_WAKE});
    repeat (2) @(posedge mclk);
    chk(pwr, 1'b1);
    wr(CMD_OFS, {28'h0, CMD_ALOOP});
    info3 <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({ldrv, rft}, 2'b01);
    rdc(IND_OFS, {27'h0, 1'b1, IND_LOOP});
    awake <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(IND_OFS, {27'h0, 1'b1, IND_AWAKE});
    awake <= 1'b0;
    info3 <= 1'b0;
    $display("Test analog done");
  endtask : t_analog

  task t_pulses;
    wr(CMD_OFS, {28'h0, CMD_SPULSE});
    pulses(SPC - BIT_CYC);
    chk(ldrv, 1'b1);
    wr(CMD_OFS, {28'h0, CMD_CPULSE});
    pulses(0);
    $display("Test pulses done");
  endtask : t_pulses

  initial begin
    {hsel, hwrite, rx_b, rx_d, line_sig, awake, info3} = 7'h0;
    {htx, pin, run, m_err} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    s_val = 4'h0;
    {bad_count, check_count, cyc, nchg} = 128'h0;
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_lock();
    t_loss();
    t_loops();
    t_analog();
    t_pulses();
    report_and_stop();
  end
endmodule : smsl_tb_top
